// File: ppvar_pkg.sv
// constants, field layouts and state type for the port channel and error register bank
package ppvar_pkg;

    // configuration byte offsets
    localparam logic [11:0] OFF_VC0_STATUS   = 12'h012A;
    localparam logic [11:0] OFF_VC1_CAP      = 12'h012C;
    localparam logic [11:0] OFF_VC1_CONTROL  = 12'h0130;
    localparam logic [11:0] OFF_VC1_STATUS   = 12'h0136;
    localparam logic [11:0] OFF_SN_HEADER    = 12'h0140;
    localparam logic [11:0] OFF_SN_LOW       = 12'h0144;
    localparam logic [11:0] OFF_SN_HIGH      = 12'h0148;
    localparam logic [11:0] OFF_AER_HEADER   = 12'h0150;
    localparam logic [11:0] OFF_UNC_STATUS   = 12'h0154;
    localparam logic [11:0] OFF_UNC_MASK     = 12'h0158;
    localparam logic [11:0] OFF_UNC_SEVERITY = 12'h015C;
    localparam logic [11:0] OFF_COR_STATUS   = 12'h0160;
    localparam logic [11:0] OFF_COR_MASK     = 12'h0164;
    localparam logic [11:0] OFF_ERR_CONTROL  = 12'h0168;
    localparam logic [11:0] OFF_HDR_LOG0     = 12'h016C;
    localparam logic [11:0] OFF_HDR_LOG1     = 12'h0170;
    localparam logic [11:0] OFF_HDR_LOG2     = 12'h0174;
    localparam logic [11:0] OFF_HDR_LOG3     = 12'h0178;

    // fixed capability contents
    localparam logic [7:0]  ARB_TYPES_SUPPORTED = 8'h01;
    localparam logic [5:0]  MAX_TIME_SLOTS      = 6'h00;
    localparam logic [7:0]  ARB_TABLE_LOCATION  = 8'h00;
    localparam logic [15:0] SN_CAP_ID           = 16'h0003;
    localparam logic [3:0]  SN_CAP_VERSION      = 4'h1;
    localparam logic [11:0] SN_NEXT_CAP         = 12'h0150;
    localparam logic [15:0] AER_CAP_ID          = 16'h0001;
    localparam logic [3:0]  AER_CAP_VERSION     = 4'h1;
    localparam logic [11:0] AER_NEXT_CAP        = 12'h0190;

    // uncorrectable error bits that software may write or clear
    localparam logic [31:0] UNC_SRC_BITS     = 32'h003D_D010;
    // read-only positions that always report fatal
    localparam logic [31:0] UNC_SEV_FIXED    = 32'h0002_2020;
    localparam logic [31:0] UNC_SEV_RESET    = 32'h0006_2030;
    localparam logic [31:0] UNC_MASK_RESET   = 32'h0000_0000;
    localparam logic [31:0] COR_SRC_BITS     = 32'h0000_31C1;
    localparam logic [31:0] COR_MASK_RESET   = 32'h0000_2000;

    // error control field positions
    localparam int ERR_CTL_GEN_EN_BIT   = 6;
    localparam int ERR_CTL_CHECK_EN_BIT = 8;

    typedef struct packed {
        logic             vc0_negotiation_pending;
        logic             vc0_table_coherency;
        logic             vc1_negotiation_pending;
        logic             vc1_table_coherency;
        logic [6:0]       vc1_class_map;
        logic [2:0]       vc1_scheme_select;
        logic [2:0]       vc1_identifier;
        logic             vc1_enable;
        logic [31:0]      unc_status;
        logic [31:0]      unc_mask;
        logic [31:0]      unc_severity;
        logic [31:0]      cor_status;
        logic [31:0]      cor_mask;
        logic [4:0]       first_error_position;
        logic             log_valid;
        logic             crc_generate_enable;
        logic             crc_check_enable;
        logic [3:0][31:0] logged_header_word;
        logic [31:0]      rdata;
        logic             rd_done;
        logic             msg_fatal;
        logic             msg_nonfatal;
        logic             msg_correctable;
    } ppvar_state_t;

    localparam ppvar_state_t PPVAR_RESET = '{
        vc0_negotiation_pending: 1'b1,
        vc1_negotiation_pending: 1'b1,
        unc_mask:                UNC_MASK_RESET,
        unc_severity:            UNC_SEV_RESET,
        cor_mask:                COR_MASK_RESET,
        default:                 '0
    };

endpackage : ppvar_pkg

// File: ppvar_registers.sv
// configuration register bank for channel status, channel 1 and advanced error reporting
`timescale 1ns/1ns

module ppvar_registers #(
    parameter logic [63:0] UNIQUE_ID = 64'h0000_0000_0000_0000
) (
    // clock and resets
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        cold_rst_b,
    // configuration access
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata_q,
    output logic             cfg_rd_done_q,
    // channel state from the port core
    input  wire logic        vc0_channel_negotiation_pending,
    input  wire logic        vc0_arbitration_table_coherency,
    input  wire logic        vc1_channel_negotiation_pending,
    input  wire logic        vc1_arbitration_table_coherency,
    // channel 1 controls to the port core
    output logic      [6:0]  vc1_class1to7_channel_map_q,
    output logic      [2:0]  vc1_arbitration_scheme_select_q,
    output logic      [2:0]  vc1_channel_identifier_q,
    output logic             vc1_channel_enable_q,
    // error sources and the header of the offending packet
    input  wire logic [31:0] unc_error_event,
    input  wire logic [31:0] cor_error_event,
    input  wire logic [31:0] err_header_word0,
    input  wire logic [31:0] err_header_word1,
    input  wire logic [31:0] err_header_word2,
    input  wire logic [31:0] err_header_word3,
    // error messages toward the root complex and crc controls
    output logic             err_msg_fatal_q,
    output logic             err_msg_nonfatal_q,
    output logic             err_msg_correctable_q,
    output logic             crc_generate_enable_q,
    output logic             crc_check_enable_q
);
    import ppvar_pkg::*;

    ppvar_state_t s_q;
    ppvar_state_t s_d;

    function automatic logic [9:0] dw(input logic [11:0] off);
        dw = off[11:2];
    endfunction : dw

    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] pos;
        pos = 5'd0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                pos = 5'(i);
            end
        end
        lowest_set = pos;
    endfunction : lowest_set

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] wmask);
        merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction : merge

    logic [31:0] be_mask;
    logic [31:0] unc_ev;
    logic [31:0] cor_ev;
    logic [31:0] unc_unmasked;
    logic [31:0] unc_after_clear;
    logic [31:0] rd_word;
    logic        log_pending;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            be_mask[b*8 +: 8] = {8{cfg_be[b]}};
        end
    end

    // read mux, no side effects on read
    always_comb begin
        rd_word = 32'h0000_0000;
        if (cfg_addr[11:2] == dw(OFF_VC0_STATUS)) begin
            rd_word = {14'h0000, s_q.vc0_negotiation_pending,
                       s_q.vc0_table_coherency, 16'h0000};
        end else if (cfg_addr[11:2] == dw(OFF_VC1_CAP)) begin
            rd_word = {ARB_TABLE_LOCATION, 2'b00, MAX_TIME_SLOTS,
                       1'b0, 7'h00, ARB_TYPES_SUPPORTED};
        end else if (cfg_addr[11:2] == dw(OFF_VC1_CONTROL)) begin
            rd_word = {s_q.vc1_enable, 4'h0, s_q.vc1_identifier, 4'h0,
                       s_q.vc1_scheme_select, 1'b0, 8'h00,
                       s_q.vc1_class_map, 1'b0};
        end else if (cfg_addr[11:2] == dw(OFF_VC1_STATUS)) begin
            rd_word = {14'h0000, s_q.vc1_negotiation_pending,
                       s_q.vc1_table_coherency, 16'h0000};
        end else if (cfg_addr[11:2] == dw(OFF_SN_HEADER)) begin
            rd_word = {SN_NEXT_CAP, SN_CAP_VERSION, SN_CAP_ID};
        end else if (cfg_addr[11:2] == dw(OFF_SN_LOW)) begin
            rd_word = UNIQUE_ID[31:0];
        end else if (cfg_addr[11:2] == dw(OFF_SN_HIGH)) begin
            rd_word = UNIQUE_ID[63:32];
        end else if (cfg_addr[11:2] == dw(OFF_AER_HEADER)) begin
            rd_word = {AER_NEXT_CAP, AER_CAP_VERSION, AER_CAP_ID};
        end else if (cfg_addr[11:2] == dw(OFF_UNC_STATUS)) begin
            rd_word = s_q.unc_status & UNC_SRC_BITS;
        end else if (cfg_addr[11:2] == dw(OFF_UNC_MASK)) begin
            rd_word = s_q.unc_mask & UNC_SRC_BITS;
        end else if (cfg_addr[11:2] == dw(OFF_UNC_SEVERITY)) begin
            rd_word = (s_q.unc_severity & UNC_SRC_BITS) | UNC_SEV_FIXED;
        end else if (cfg_addr[11:2] == dw(OFF_COR_STATUS)) begin
            rd_word = s_q.cor_status & COR_SRC_BITS;
        end else if (cfg_addr[11:2] == dw(OFF_COR_MASK)) begin
            rd_word = s_q.cor_mask & COR_SRC_BITS;
        end else if (cfg_addr[11:2] == dw(OFF_ERR_CONTROL)) begin
            rd_word = {23'h00_0000, s_q.crc_check_enable, 1'b0,
                       s_q.crc_generate_enable, 1'b0,
                       s_q.first_error_position};
        end else if (cfg_addr[11:2] == dw(OFF_HDR_LOG0)) begin
            rd_word = s_q.logged_header_word[0];
        end else if (cfg_addr[11:2] == dw(OFF_HDR_LOG1)) begin
            rd_word = s_q.logged_header_word[1];
        end else if (cfg_addr[11:2] == dw(OFF_HDR_LOG2)) begin
            rd_word = s_q.logged_header_word[2];
        end else if (cfg_addr[11:2] == dw(OFF_HDR_LOG3)) begin
            rd_word = s_q.logged_header_word[3];
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rd_done = 1'b0;
        s_d.msg_fatal = 1'b0;
        s_d.msg_nonfatal = 1'b0;
        s_d.msg_correctable = 1'b0;

        s_d.vc0_negotiation_pending = vc0_channel_negotiation_pending;
        s_d.vc1_negotiation_pending = vc1_channel_negotiation_pending;
        s_d.vc0_table_coherency = vc0_arbitration_table_coherency;
        s_d.vc1_table_coherency = vc1_arbitration_table_coherency;

        // read-only positions never latch an event
        unc_ev = unc_error_event & UNC_SRC_BITS;
        cor_ev = cor_error_event & COR_SRC_BITS;
        unc_unmasked = unc_ev & ~s_q.unc_mask;

        unc_after_clear = s_q.unc_status;
        if (cfg_wr) begin
            if (cfg_addr[11:2] == dw(OFF_VC1_CONTROL)) begin
                if (cfg_be[0]) begin
                    s_d.vc1_class_map = cfg_wdata[7:1];
                end
                if (cfg_be[2]) begin
                    s_d.vc1_scheme_select = cfg_wdata[19:17];
                end
                if (cfg_be[3]) begin
                    s_d.vc1_identifier = cfg_wdata[26:24];
                    s_d.vc1_enable = cfg_wdata[31];
                end
            end else if (cfg_addr[11:2] == dw(OFF_UNC_STATUS)) begin
                // write one to clear
                unc_after_clear = s_q.unc_status & ~(cfg_wdata & be_mask & UNC_SRC_BITS);
            end else if (cfg_addr[11:2] == dw(OFF_UNC_MASK)) begin
                s_d.unc_mask = merge(s_q.unc_mask, cfg_wdata,
                                     be_mask & UNC_SRC_BITS);
            end else if (cfg_addr[11:2] == dw(OFF_UNC_SEVERITY)) begin
                s_d.unc_severity = merge(s_q.unc_severity, cfg_wdata,
                                         be_mask & UNC_SRC_BITS);
            end else if (cfg_addr[11:2] == dw(OFF_COR_STATUS)) begin
                s_d.cor_status = s_q.cor_status & ~(cfg_wdata & be_mask & COR_SRC_BITS);
            end else if (cfg_addr[11:2] == dw(OFF_COR_MASK)) begin
                s_d.cor_mask = merge(s_q.cor_mask, cfg_wdata,
                                     be_mask & COR_SRC_BITS);
            end else if (cfg_addr[11:2] == dw(OFF_ERR_CONTROL)) begin
                s_d.crc_generate_enable = cfg_be[0] ? cfg_wdata[ERR_CTL_GEN_EN_BIT]
                                                    : s_q.crc_generate_enable;
                s_d.crc_check_enable = cfg_be[1] ? cfg_wdata[ERR_CTL_CHECK_EN_BIT]
                                                 : s_q.crc_check_enable;
            end
        end

        // a new event beats a clear in the same cycle
        s_d.unc_status = unc_after_clear | unc_ev;
        s_d.cor_status = s_d.cor_status | cor_ev;

        s_d.msg_fatal = |(unc_unmasked & s_q.unc_severity);
        s_d.msg_nonfatal = |(unc_unmasked & ~s_q.unc_severity);
        s_d.msg_correctable = |(cor_ev & ~s_q.cor_mask);

        // keep the first capture until software clears the logged status bit
        log_pending = s_q.log_valid && unc_after_clear[s_q.first_error_position];
        if ((|unc_unmasked) && !log_pending) begin
            s_d.first_error_position = lowest_set(unc_unmasked);
            s_d.log_valid = 1'b1;
            s_d.logged_header_word[0] = err_header_word0;
            s_d.logged_header_word[1] = err_header_word1;
            s_d.logged_header_word[2] = err_header_word2;
            s_d.logged_header_word[3] = err_header_word3;
        end

        if (cfg_rd) begin
            s_d.rdata = rd_word;
            s_d.rd_done = 1'b1;
        end

        // warm reset returns everything but the sticky error status and log state to its reset value
        if (!rst_b) begin
            s_d = PPVAR_RESET;
            s_d.unc_status = s_q.unc_status;
            s_d.cor_status = s_q.cor_status;
            s_d.first_error_position = s_q.first_error_position;
            s_d.log_valid = s_q.log_valid;
            s_d.logged_header_word = s_q.logged_header_word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!cold_rst_b) begin
            s_q <= PPVAR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata_q                     = s_q.rdata;
    assign cfg_rd_done_q                   = s_q.rd_done;
    assign vc1_class1to7_channel_map_q     = s_q.vc1_class_map;
    assign vc1_arbitration_scheme_select_q = s_q.vc1_scheme_select;
    assign vc1_channel_identifier_q        = s_q.vc1_identifier;
    assign vc1_channel_enable_q            = s_q.vc1_enable;
    assign err_msg_fatal_q                 = s_q.msg_fatal;
    assign err_msg_nonfatal_q              = s_q.msg_nonfatal;
    assign err_msg_correctable_q           = s_q.msg_correctable;
    assign crc_generate_enable_q           = s_q.crc_generate_enable;
    assign crc_check_enable_q              = s_q.crc_check_enable;

endmodule : ppvar_registers

// File: ppvar_registers_monitor.sv
// concurrent checks on the channel and error register bank ports
`timescale 1ns/1ns
module ppvar_registers_monitor #(
    parameter logic [63:0] UNIQUE_ID = 64'h0000_0000_0000_0000
) (
    // clock and resets
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        cold_rst_b,
    // configuration access
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [31:0] cfg_rdata_q,
    // controls and messages
    input  wire logic [6:0]  vc1_class1to7_channel_map_q,
    input  wire logic [2:0]  vc1_arbitration_scheme_select_q,
    input  wire logic [2:0]  vc1_channel_identifier_q,
    input  wire logic        vc1_channel_enable_q,
    input  wire logic [31:0] cor_error_event,
    input  wire logic        err_msg_correctable_q,
    input  wire logic        crc_generate_enable_q,
    input  wire logic        crc_check_enable_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b || !cold_rst_b);
    logic [9:0] dw;
    assign dw = cfg_addr[11:2];

    a_serial_header: assert property (cfg_rd && dw == 10'h050 |=> cfg_rdata_q == 32'h1501_0003)
        else $error("serial capability header wrong");
    a_error_header: assert property (cfg_rd && dw == 10'h054 |=> cfg_rdata_q == 32'h1901_0001)
        else $error("error reporting header wrong");
    a_vc1_cap_fixed: assert property (cfg_rd && dw == 10'h04B |=> cfg_rdata_q == 32'h0000_0001)
        else $error("channel 1 capability wrong");
    a_serial_words: assert property (cfg_rd && (dw == 10'h051 || dw == 10'h052) |=>
        cfg_rdata_q == ($past(cfg_addr[2]) ? UNIQUE_ID[31:0] : UNIQUE_ID[63:32]))
        else $error("unique id word wrong");
    a_vc1_ctrl_write: assert property (cfg_wr && dw == 10'h04C && cfg_be == 4'hF |=>
        vc1_channel_enable_q == $past(cfg_wdata[31]) &&
        vc1_channel_identifier_q == $past(cfg_wdata[26:24]) &&
        vc1_arbitration_scheme_select_q == $past(cfg_wdata[19:17]) &&
        vc1_class1to7_channel_map_q == $past(cfg_wdata[7:1]))
        else $error("channel 1 control not loaded");
    a_vc1_ctrl_ro: assert property (cfg_rd && dw == 10'h04C |=> !cfg_rdata_q[16] &&
        !cfg_rdata_q[0] && cfg_rdata_q[31] == $past(vc1_channel_enable_q))
        else $error("channel 1 control readback wrong");
    a_crc_enable_write: assert property (cfg_wr && dw == 10'h05A && cfg_be[1:0] == 2'b11 |=>
        crc_generate_enable_q == $past(cfg_wdata[6]) && crc_check_enable_q == $past(cfg_wdata[8]))
        else $error("crc enables not loaded");
    a_crc_cap_zero: assert property (cfg_rd && dw == 10'h05A |=> !cfg_rdata_q[5] &&
        !cfg_rdata_q[7] && cfg_rdata_q[6] == $past(crc_generate_enable_q))
        else $error("error control readback wrong");
    a_fixed_unc_bits: assert property (cfg_rd && (dw == 10'h055 || dw == 10'h056) |=>
        !cfg_rdata_q[5] && !cfg_rdata_q[13] && !cfg_rdata_q[17])
        else $error("fixed uncorrectable bit set");
    a_cor_msg_cause: assert property (err_msg_correctable_q |->
        ($past(cor_error_event) & 32'h0000_31C1) != 32'h0000_0000)
        else $error("correctable message without event");
endmodule : ppvar_registers_monitor

bind ppvar_registers ppvar_registers_monitor #(.UNIQUE_ID(UNIQUE_ID)) ppvar_registers_monitor_inst (
    .core_clk, .rst_b, .cold_rst_b, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_q,
    .vc1_class1to7_channel_map_q, .vc1_arbitration_scheme_select_q, .vc1_channel_identifier_q,
    .vc1_channel_enable_q, .cor_error_event, .err_msg_correctable_q, .crc_generate_enable_q,
    .crc_check_enable_q);

// File: ppvar_registers_test.sv
// self-checking bench for the channel and error register bank
`timescale 1ns/1ns
module ppvar_registers_test;
    localparam logic [63:0] UID = 64'h0123_4567_89AB_CDEF;
    localparam logic [11:0] RA [19] = '{12'h12A, 12'h12C, 12'h130, 12'h136, 12'h140, 12'h144,
        12'h148, 12'h150, 12'h154, 12'h158, 12'h15C, 12'h160, 12'h164, 12'h168, 12'h16C,
        12'h170, 12'h174, 12'h178, 12'h3FC};
    localparam logic [31:0] RV [19] = '{32'h0002_0000, 32'h0000_0001, 32'h0, 32'h0001_0000,
        32'h1501_0003, UID[31:0], UID[63:32], 32'h1901_0001, 32'h0, 32'h0, 32'h0006_2030,
        32'h0, 32'h0000_2000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [7:0] UB [9] = '{8'h04, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h12, 8'h13, 8'h14,
        8'h15};
    localparam logic [7:0] CB [6] = '{8'h00, 8'h06, 8'h07, 8'h08, 8'h0C, 8'h0D};
    logic        core_clk, rst_b, cold_rst_b, cfg_rd, cfg_wr, cfg_rd_done_q;
    logic [11:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata_q, unc_error_event, cor_error_event;
    logic [31:0] err_header_word0, err_header_word1, err_header_word2, err_header_word3;
    logic        vc0_channel_negotiation_pending, vc0_arbitration_table_coherency;
    logic        vc1_channel_negotiation_pending, vc1_arbitration_table_coherency;
    logic [6:0]  vc1_class1to7_channel_map_q;
    logic [2:0]  vc1_arbitration_scheme_select_q, vc1_channel_identifier_q;
    logic        vc1_channel_enable_q, err_msg_fatal_q, err_msg_nonfatal_q;
    logic        err_msg_correctable_q, crc_generate_enable_q, crc_check_enable_q;
    int          fail_count = 0;
    int          samples_checked = 0;

    ppvar_registers #(.UNIQUE_ID(UID)) ppvar_registers_inst (.core_clk, .rst_b, .cold_rst_b,
        .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_q, .cfg_rd_done_q,
        .vc0_channel_negotiation_pending, .vc0_arbitration_table_coherency,
        .vc1_channel_negotiation_pending, .vc1_arbitration_table_coherency,
        .vc1_class1to7_channel_map_q, .vc1_arbitration_scheme_select_q, .vc1_channel_identifier_q,
        .vc1_channel_enable_q, .unc_error_event, .cor_error_event, .err_header_word0,
        .err_header_word1, .err_header_word2, .err_header_word3, .err_msg_fatal_q,
        .err_msg_nonfatal_q, .err_msg_correctable_q, .crc_generate_enable_q, .crc_check_enable_q);

    task automatic end_of_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge core_clk);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
        @(negedge core_clk);
        cfg_wr = 1'b0;
    endtask : wr

    // bounded wait on the done pulse, then compare the read data
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        int n;
        @(negedge core_clk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge core_clk);
        cfg_rd = 1'b0;
        n = 0;
        while (cfg_rd_done_q !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        chk(32'(cfg_rd_done_q), 32'h1);
        chk(cfg_rdata_q, exp);
    endtask : rd

    // one event pulse; messages are gathered as {fatal, nonfatal, correctable}
    task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic [31:0] h,
                      input logic [2:0] exp);
        logic [2:0] seen;
        @(negedge core_clk);
        {unc_error_event, cor_error_event} = {u, c};
        {err_header_word0, err_header_word1, err_header_word2, err_header_word3} =
            {h, h + 32'h1, h + 32'h2, h + 32'h3};
        seen = 3'b000;
        repeat (3) begin
            @(negedge core_clk);
            {unc_error_event, cor_error_event} = 64'h0;
            seen |= {err_msg_fatal_q, err_msg_nonfatal_q, err_msg_correctable_q};
        end
        chk(32'(seen), 32'(exp));
    endtask : ev

    task automatic rst(input logic cold);
        @(negedge core_clk);
        {rst_b, cold_rst_b} = {1'b0, !cold};
        repeat (12) @(negedge core_clk);
        {rst_b, cold_rst_b} = 2'b11;
    endtask : rst

    task automatic chk_table();
        for (int i = 0; i < 19; i++) rd(RA[i], RV[i]);
    endtask : chk_table

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        {rst_b, cold_rst_b, cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
        {unc_error_event, cor_error_event, err_header_word0, err_header_word1} = '0;
        {err_header_word2, err_header_word3} = '0;
        {vc0_channel_negotiation_pending, vc0_arbitration_table_coherency} = 2'b10;
        {vc1_channel_negotiation_pending, vc1_arbitration_table_coherency} = 2'b01;
        rst(1'b1);
        chk_table();
        wr(12'h130, 4'hF, 32'hFFFF_FFFF);
        rd(12'h130, 32'h870E_00FE);
        chk(32'({vc1_channel_enable_q, vc1_channel_identifier_q, vc1_arbitration_scheme_select_q,
            vc1_class1to7_channel_map_q}), 32'h0000_3FFF);
        wr(12'h12C, 4'hF, 32'hFFFF_FFFF);
        rd(12'h12C, 32'h0000_0001);
        wr(12'h144, 4'hF, 32'hFFFF_FFFF);
        rd(12'h144, UID[31:0]);
        wr(12'h158, 4'hF, 32'hFFFF_FFFF);
        rd(12'h158, 32'h003D_D010);
        wr(12'h15C, 4'hF, 32'h0);
        rd(12'h15C, 32'h0002_2020);
        wr(12'h164, 4'hF, 32'hFFFF_FFFF);
        rd(12'h164, 32'h0000_31C1);
        wr(12'h168, 4'hF, 32'hFFFF_FFFF);
        rd(12'h168, 32'h0000_0140);
        wr(12'h168, 4'b0010, 32'h0);
        rd(12'h168, 32'h0000_0040);
        chk(32'({crc_generate_enable_q, crc_check_enable_q}), 32'h0000_0002);
        wr(12'h158, 4'hF, 32'h0000_4000);
        wr(12'h15C, 4'hF, 32'h0000_0010);
        wr(12'h164, 4'hF, 32'h0000_2000);
        ev(32'h0000_1000, 32'h0, 32'hA000_0000, 3'b010);
        rd(12'h154, 32'h0000_1000);
        rd(12'h168, 32'h0000_004C);
        for (int i = 0; i < 4; i++) rd(12'h16C + 12'(4 * i), 32'hA000_0000 + 32'(i));
        ev(32'h0000_0010, 32'h0, 32'hB000_0000, 3'b100);
        rd(12'h168, 32'h0000_004C);
        rd(12'h16C, 32'hA000_0000);
        ev(32'h0000_4000, 32'h0, 32'hC000_0000, 3'b000);
        rd(12'h154, 32'h0000_5010);
        wr(12'h154, 4'hF, 32'h0000_1000);
        rd(12'h154, 32'h0000_4010);
        ev(32'h0010_4000, 32'h0, 32'hD000_0000, 3'b010);
        rd(12'h168, 32'h0000_0054);
        rd(12'h170, 32'hD000_0001);
        wr(12'h158, 4'hF, 32'h0);
        for (int i = 0; i < 9; i++) begin
            wr(12'h154, 4'hF, 32'hFFFF_FFFF);
            ev(32'h1 << UB[i], 32'h0, {UB[i], 24'h00_0000},
               UB[i] == 8'h04 ? 3'b100 : 3'b010);
            rd(12'h154, 32'h1 << UB[i]);
        end
        for (int i = 0; i < 6; i++) begin
            wr(12'h160, 4'hF, 32'hFFFF_FFFF);
            ev(32'h0, 32'h1 << CB[i], 32'h0, CB[i] == 8'h0D ? 3'b000 : 3'b001);
            rd(12'h160, 32'h1 << CB[i]);
        end
        // swapped channel inputs must show up in both status words
        {vc0_channel_negotiation_pending, vc0_arbitration_table_coherency} = 2'b01;
        {vc1_channel_negotiation_pending, vc1_arbitration_table_coherency} = 2'b10;
        rd(12'h12A, 32'h0001_0000);
        rd(12'h136, 32'h0002_0000);
        // warm reset keeps sticky state, returns the rest to reset values
        rst(1'b0);
        rd(12'h154, 32'h0020_0000);
        rd(12'h160, 32'h0000_2000);
        rd(12'h168, 32'h0000_0015);
        rd(12'h16C, 32'h1500_0000);
        rd(12'h178, 32'h1500_0003);
        rd(12'h15C, 32'h0006_2030);
        rd(12'h130, 32'h0);
        {vc0_channel_negotiation_pending, vc0_arbitration_table_coherency} = 2'b10;
        {vc1_channel_negotiation_pending, vc1_arbitration_table_coherency} = 2'b01;
        rst(1'b1);
        chk_table();
        end_of_test();
    end
endmodule : ppvar_registers_test
